/* core/sio_cfg_map.vh */
// address map, key bytes, field positions and reset values of the configuration front end
// Behaviour
// RULE_01 - The host unlocks configuration mode, then accesses registers, then locks it again.
// RULE_02 - Configuration mode is entered only after two back-to-back writes of 87h to the enable port.
// RULE_03 - The index port sits at the enable port address and the data port at the next address.
// RULE_04 - Writing index 07h then a number to the data port selects the logical device for later accesses.
// RULE_05 - Global registers below 30h are reachable whatever logical device is selected.
// RULE_06 - An index write followed by a data-port access writes or reads the indexed register.
// RULE_07 - Writing AAh to the enable port leaves configuration mode.
// RULE_08 - After leaving, the device runs normally and accepts the entry key again.
// RULE_09 - With bit 6 of register 26h set, the ports move from 2Eh/2Fh to 4Eh/4Fh.
// RULE_10 - Strapped bits take pin levels sampled at reset and version bits read the revision.
// RULE_11 - A read-only 16-bit chip identity sits at 20h (high) and 21h (low, revision in low nibble).
// RULE_12 - Outside configuration mode non-key writes are ignored and restart key detection.
`ifndef SIO_CFG_MAP_VH
`define SIO_CFG_MAP_VH

`define SIO_PORT_BASE_DEF      16'h002e
`define SIO_PORT_BASE_ALT      16'h004e
`define SIO_KEY_ENTER          8'h87
`define SIO_KEY_EXIT           8'haa

`define SIO_IDX_SOFT_RESET     8'h02
`define SIO_IDX_LDN            8'h07
`define SIO_IDX_ID_HIGH        8'h20
`define SIO_IDX_ID_LOW         8'h21
`define SIO_IDX_PWR_A          8'h22
`define SIO_IDX_PWR_B          8'h23
`define SIO_IDX_OPT_A          8'h24
`define SIO_IDX_TRISTATE       8'h25
`define SIO_IDX_OPT_B          8'h26
`define SIO_IDX_RSVD_A         8'h27
`define SIO_IDX_OPT_C          8'h28
`define SIO_IDX_PIN_A          8'h29
`define SIO_IDX_TWO_WIRE       8'h2a
`define SIO_IDX_RSVD_B         8'h2b
`define SIO_IDX_PIN_B          8'h2c
`define SIO_IDX_GP2_DETECT     8'h2d
`define SIO_IDX_RSVD_C         8'h2e
`define SIO_IDX_RSVD_D         8'h2f
`define SIO_IDX_DEVICE_FIRST   8'h30

`define SIO_ALT_PORT_BIT       6
`define SIO_OPT_A_STRAP_LO     1
`define SIO_OPT_A_STRAP_HI     2
`define SIO_STRAP_WAIT         3'h4
`define SIO_STRAP_DONE         3'h5

`define SIO_RST_LDN            8'h00
`define SIO_RST_PWR_A          8'hff
`define SIO_RST_PWR_B          8'hf0
`define SIO_RST_OPT_A          8'h40
`define SIO_RST_ZERO           8'h00
`define SIO_RST_PIN_B          8'h02

`endif

/* core/sio_sync3.v */
// three-flop synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module sio_sync3 #(
   parameter RESET_VAL = 1'b0
) (
   input  wire core_clk_i,
   input  wire reset_i,
   input  wire async_i,
   output reg  sync_o
);
   reg stage_a;
   reg stage_b;
   reg stage_c;

   always @(posedge core_clk_i) begin
      if (reset_i) begin
         stage_a <= RESET_VAL;
         stage_b <= RESET_VAL;
         stage_c <= RESET_VAL;
         sync_o  <= RESET_VAL;
      end else begin
         stage_a <= async_i;
         stage_b <= stage_a;
         stage_c <= stage_b;
         if (stage_b == stage_c) begin
            sync_o <= stage_c;
         end
      end
   end
endmodule

/* core/sio_cfg_access.v */
// key-protected index/data configuration front end with the global register bank
`timescale 1ns/1ps
`include "sio_cfg_map.vh"
module sio_cfg_access #(
   parameter [11:0] CHIP_ID_CODE  = 12'h5a5,   // arbitrary identity value
   parameter [3:0]  SILICON_REV   = 4'h1       // arbitrary revision value
) (
   input  wire       core_clk_i,
   input  wire       reset_i,
   input  wire       io_wr_i,
   input  wire       io_rd_i,
   input  wire [15:0] io_addr_i,
   input  wire [7:0] io_wdata_i,
   input  wire       strap_alt_port_i,
   input  wire [1:0] strap_opt_a_i,
   input  wire [7:0] dev_rdata_i,
   output reg  [7:0] io_rdata_o,
   output reg        io_hit_o,
   output reg        config_mode_o,
   output reg  [7:0] logical_device_o,
   output reg  [7:0] dev_index_o,
   output reg        dev_wr_o,
   output reg        dev_rd_o,
   output reg  [7:0] dev_wdata_o,
   output reg        soft_reset_o,
   output reg  [7:0] power_down_a_o,
   output reg  [7:0] power_down_b_o,
   output reg  [7:0] tristate_o,
   output reg  [7:0] pin_select_a_o,
   output reg  [7:0] pin_select_b_o
);
   localparam [1:0] ST_LOCKED = 2'h0;
   localparam [1:0] ST_KEY1   = 2'h1;
   localparam [1:0] ST_OPEN   = 2'h2;

   reg  [1:0] state;
   reg  [1:0] next_state;
   reg  [7:0] index_reg;
   reg  [7:0] ldn_reg;
   reg  [7:0] opt_a;
   reg  [7:0] opt_b;
   reg  [7:0] opt_c;
   reg  [7:0] two_wire;
   reg  [7:0] gp2_detect;
   reg  [7:0] rsvd_c;
   reg  [7:0] rsvd_d;
   reg  [2:0] strap_wait;
   reg  [7:0] glob_rdata;
   wire       alt_sync;
   wire [1:0] opt_a_sync;
   wire       alt_port_select_flag;
   wire [15:0] base_addr;
   wire       hit_index;
   wire       hit_data;
   wire       data_wr;
   wire       data_rd;
   wire       is_global;

   sio_sync3 #(.RESET_VAL(1'b0)) u_sync_alt (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .async_i    (strap_alt_port_i),
      .sync_o     (alt_sync)
   );

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_opt_sync
         sio_sync3 #(.RESET_VAL(1'b0)) u_sync (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .async_i    (strap_opt_a_i[g]),
            .sync_o     (opt_a_sync[g])
         );
      end
   endgenerate

   assign alt_port_select_flag = opt_b[`SIO_ALT_PORT_BIT];
   assign base_addr = alt_port_select_flag ? `SIO_PORT_BASE_ALT : `SIO_PORT_BASE_DEF; // [RULE_09]
   assign hit_index = (io_addr_i == base_addr);                                       // [RULE_03]
   assign hit_data  = (io_addr_i == (base_addr + 16'h0001));                          // [RULE_03]
   // the data port only responds while unlocked
   assign data_wr   = io_wr_i && hit_data && (state == ST_OPEN);
   assign data_rd   = io_rd_i && hit_data && (state == ST_OPEN);
   assign is_global = (index_reg < `SIO_IDX_DEVICE_FIRST);                            // [RULE_05]

   // key detector
   always @* begin
      next_state = state;
      case (state)
         ST_LOCKED: begin
            if (io_wr_i && hit_index && io_wdata_i == `SIO_KEY_ENTER) begin
               next_state = ST_KEY1;                                                 // [RULE_02]
            end
         end
         ST_KEY1: begin
            if (io_wr_i) begin
               if (hit_index && io_wdata_i == `SIO_KEY_ENTER) begin
                  next_state = ST_OPEN;                                              // [RULE_02]
               end else begin
                  next_state = ST_LOCKED;                                            // [RULE_12]
               end
            end
         end
         ST_OPEN: begin
            if (io_wr_i && hit_index && io_wdata_i == `SIO_KEY_EXIT) begin
               next_state = ST_LOCKED;                                               // [RULE_07] [RULE_08]
            end
         end
         default: next_state = ST_LOCKED;
      endcase
   end

   // global register read mux
   always @* begin
      case (index_reg)
         `SIO_IDX_LDN:        glob_rdata = ldn_reg;
         `SIO_IDX_ID_HIGH:    glob_rdata = CHIP_ID_CODE[11:4];                        // [RULE_11]
         `SIO_IDX_ID_LOW:     glob_rdata = {CHIP_ID_CODE[3:0], SILICON_REV};          // [RULE_10] [RULE_11]
         `SIO_IDX_PWR_A:      glob_rdata = power_down_a_o;
         `SIO_IDX_PWR_B:      glob_rdata = power_down_b_o;
         `SIO_IDX_OPT_A:      glob_rdata = opt_a;
         `SIO_IDX_TRISTATE:   glob_rdata = tristate_o;
         `SIO_IDX_OPT_B:      glob_rdata = opt_b;
         `SIO_IDX_OPT_C:      glob_rdata = opt_c;
         `SIO_IDX_PIN_A:      glob_rdata = pin_select_a_o;
         `SIO_IDX_TWO_WIRE:   glob_rdata = two_wire;
         `SIO_IDX_PIN_B:      glob_rdata = pin_select_b_o;
         `SIO_IDX_GP2_DETECT: glob_rdata = gp2_detect;
         `SIO_IDX_RSVD_C:     glob_rdata = rsvd_c;
         `SIO_IDX_RSVD_D:     glob_rdata = rsvd_d;
         default:             glob_rdata = 8'h00;
      endcase
   end

   always @(posedge core_clk_i) begin
      if (reset_i) begin
         state            <= ST_LOCKED;
         index_reg        <= 8'h00;
         ldn_reg          <= `SIO_RST_LDN;
         power_down_a_o   <= `SIO_RST_PWR_A;
         power_down_b_o   <= `SIO_RST_PWR_B;
         opt_a            <= `SIO_RST_OPT_A;
         tristate_o       <= `SIO_RST_ZERO;
         opt_b            <= `SIO_RST_ZERO;
         opt_c            <= `SIO_RST_ZERO;
         pin_select_a_o   <= `SIO_RST_ZERO;
         two_wire         <= `SIO_RST_ZERO;
         pin_select_b_o   <= `SIO_RST_PIN_B;
         gp2_detect       <= `SIO_RST_ZERO;
         rsvd_c           <= `SIO_RST_ZERO;
         rsvd_d           <= `SIO_RST_ZERO;
         strap_wait       <= 3'h0;
         io_rdata_o       <= 8'h00;
         io_hit_o         <= 1'b0;
         config_mode_o    <= 1'b0;
         logical_device_o <= `SIO_RST_LDN;
         dev_index_o      <= 8'h00;
         dev_wr_o         <= 1'b0;
         dev_rd_o         <= 1'b0;
         dev_wdata_o      <= 8'h00;
         soft_reset_o     <= 1'b0;
      end else begin
         state         <= next_state;
         config_mode_o <= (next_state == ST_OPEN);
         dev_wr_o      <= 1'b0;
         dev_rd_o      <= 1'b0;
         soft_reset_o  <= 1'b0;
         // straps caught once, only after the synchronisers have settled on the pins
         if (strap_wait != `SIO_STRAP_DONE) begin
            strap_wait <= strap_wait + 3'h1;
            if (strap_wait == `SIO_STRAP_WAIT) begin
               opt_a[`SIO_OPT_A_STRAP_HI:`SIO_OPT_A_STRAP_LO] <= opt_a_sync;         // [RULE_10]
               opt_b[`SIO_ALT_PORT_BIT] <= alt_sync;                                   // [RULE_10]
            end
         end
         // index port writes only count while unlocked; the exit key AAh never lands here
         if (io_wr_i && hit_index && state == ST_OPEN
             && io_wdata_i != `SIO_KEY_EXIT) begin
            index_reg <= io_wdata_i;                                                  // [RULE_06] [RULE_12]
         end
         if (data_wr) begin
            if (is_global) begin
               case (index_reg)
                  `SIO_IDX_SOFT_RESET: soft_reset_o <= 1'b1;
                  `SIO_IDX_LDN: begin
                     ldn_reg          <= io_wdata_i;                                  // [RULE_04]
                     logical_device_o <= io_wdata_i;                                  // [RULE_04]
                  end
                  `SIO_IDX_PWR_A:      power_down_a_o <= io_wdata_i;
                  `SIO_IDX_PWR_B:      power_down_b_o <= io_wdata_i;
                  `SIO_IDX_OPT_A:      opt_a          <= io_wdata_i;
                  `SIO_IDX_TRISTATE:   tristate_o     <= io_wdata_i;
                  `SIO_IDX_OPT_B:      opt_b          <= io_wdata_i;                  // [RULE_09]
                  `SIO_IDX_OPT_C:      opt_c          <= io_wdata_i;
                  `SIO_IDX_PIN_A:      pin_select_a_o <= io_wdata_i;
                  `SIO_IDX_TWO_WIRE:   two_wire       <= io_wdata_i;
                  `SIO_IDX_PIN_B:      pin_select_b_o <= io_wdata_i;
                  `SIO_IDX_GP2_DETECT: gp2_detect     <= io_wdata_i;
                  `SIO_IDX_RSVD_C:     rsvd_c         <= io_wdata_i;
                  `SIO_IDX_RSVD_D:     rsvd_d         <= io_wdata_i;
                  default:             rsvd_c         <= rsvd_c;
               endcase
            end else begin
               dev_wr_o    <= 1'b1;                                                   // [RULE_06]
               dev_index_o <= index_reg;
               dev_wdata_o <= io_wdata_i;
            end
         end
         if (data_rd && !is_global) begin
            dev_rd_o    <= 1'b1;                                                      // [RULE_06]
            dev_index_o <= index_reg;
         end
         // read answer one cycle after the strobe
         io_hit_o <= io_rd_i && (hit_data || hit_index) && (state == ST_OPEN);
         if (io_rd_i && hit_index && state == ST_OPEN) begin
            io_rdata_o <= index_reg;
         end else if (data_rd) begin
            io_rdata_o <= is_global ? glob_rdata : dev_rdata_i;                       // [RULE_05] [RULE_06]
         end else begin
            io_rdata_o <= 8'h00;
         end
      end
   end
endmodule

/* dv/sio_cfg_access_sva.sv */
// protocol checker for the configuration front end
`timescale 1ns/1ps
module sio_cfg_access_sva (
   input wire       core_clk_i,
   input wire       reset_i,
   input wire       io_wr_i,
   input wire       io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] io_rdata_o,
   input wire       io_hit_o,
   input wire       config_mode_o,
   input wire [7:0] logical_device_o,
   input wire       dev_wr_o,
   input wire       dev_rd_o,
   input wire [7:0] dev_wdata_o,
   input wire [7:0] power_down_a_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   property p_enter;
      $rose(config_mode_o) |-> $past(io_wr_i) && $past(io_wdata_i) == 8'h87;
   endproperty
   a_enter: assert property (p_enter) else $error("mode opened without key");
   // reset also drops the mode, so skip the edge after it
   property p_exit;
      $fell(config_mode_o) && !$past(reset_i) |-> $past(io_wr_i) && $past(io_wdata_i) == 8'haa;
   endproperty
   a_exit: assert property (p_exit) else $error("mode closed without exit key");
   property p_hit;
      io_hit_o |-> $past(io_rd_i) && $past(config_mode_o);
   endproperty
   a_hit: assert property (p_hit) else $error("hit without unlocked read");
   property p_rdata_idle;
      !$past(io_rd_i) |-> io_rdata_o == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   property p_ldn;
      !$past(reset_i) && $changed(logical_device_o) |->
         $past(io_wr_i && config_mode_o) && logical_device_o == $past(io_wdata_i);
   endproperty
   a_ldn: assert property (p_ldn) else $error("device number changed oddly");
   property p_dev_wr;
      dev_wr_o |-> $past(io_wr_i && config_mode_o) && dev_wdata_o == $past(io_wdata_i);
   endproperty
   a_dev_wr: assert property (p_dev_wr) else $error("bad device write");
   property p_dev_rd;
      dev_rd_o |-> $past(io_rd_i && config_mode_o) ##1 !dev_rd_o || $past(io_rd_i);
   endproperty
   a_dev_rd: assert property (p_dev_rd) else $error("bad device read");
   property p_locked;
      !config_mode_o |=> $stable(power_down_a_o);
   endproperty
   a_locked: assert property (p_locked) else $error("register moved while locked");
endmodule
bind sio_cfg_access sio_cfg_access_sva sio_cfg_access_sva_i (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
   .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o), .config_mode_o(config_mode_o),
   .logical_device_o(logical_device_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o),
   .dev_wdata_o(dev_wdata_o), .power_down_a_o(power_down_a_o));

/* dv/sio_host_model.sv */
// host model issuing single i/o write and read cycles
`timescale 1ns/1ps
module sio_host_model (
   input  wire        core_clk_i,
   input  wire [7:0]  io_rdata_i,
   input  wire        io_hit_i,
   output reg         io_wr_o,
   output reg         io_rd_o,
   output reg  [15:0] io_addr_o,
   output reg  [7:0]  io_wdata_o
);
   initial begin
      io_wr_o = 1'b0;
      io_rd_o = 1'b0;
      io_addr_o = 16'hffff;
      io_wdata_o = 8'h00;
   end
   // caller orders unlock, access, lock
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(posedge core_clk_i);
         #2;
         io_addr_o = a;
         io_wdata_o = d;
         io_wr_o = 1'b1;
         @(posedge core_clk_i);
         #2;
         io_wr_o = 1'b0;
         io_addr_o = 16'hffff;
         // released data must not keep the old value
         io_wdata_o = ~d;
      end
   endtask
   task rd(input [15:0] a, output [7:0] d, output h);
      begin
         @(posedge core_clk_i);
         #2;
         io_addr_o = a;
         io_rd_o = 1'b1;
         @(posedge core_clk_i);
         #2;
         io_rd_o = 1'b0;
         io_addr_o = 16'hffff;
         d = io_rdata_i;
         h = io_hit_i;
      end
   endtask
endmodule

/* dv/sio_cfg_access_tb_top.sv */
// self-checking testbench of the configuration front end
`timescale 1ns/1ps
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
   num_errors = num_errors + 1; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module sio_cfg_access_tb_top;
   localparam [15:0] B = 16'h002e;
   localparam [15:0] A = 16'h004e;
   reg        core_clk_i = 1'b0;
   reg        reset_i = 1'b1;
   wire       wr, rd, hit, cm, dwr, drd, srst;
   wire [15:0] addr;
   wire [7:0] wd, rdat, ldn, dix, dwd, pa, pb, ts, sa, sb;
   integer    num_errors = 0;
   integer    checks = 0;
   integer    i;
   reg  [7:0] d;
   reg        h;
   reg  [7:0] ix;
   always #25 core_clk_i = ~core_clk_i;
   sio_host_model sio_host_model_i (.core_clk_i(core_clk_i), .io_rdata_i(rdat),
      .io_hit_i(hit), .io_wr_o(wr), .io_rd_o(rd), .io_addr_o(addr), .io_wdata_o(wd));
   sio_cfg_access sio_cfg_access_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .io_wr_i(wr), .io_rd_i(rd), .io_addr_i(addr), .io_wdata_i(wd),
      .strap_alt_port_i(1'b0), .strap_opt_a_i(2'b10), .dev_rdata_i(dix ^ 8'ha5),
      .io_rdata_o(rdat), .io_hit_o(hit), .config_mode_o(cm), .logical_device_o(ldn),
      .dev_index_o(dix), .dev_wr_o(dwr), .dev_rd_o(drd), .dev_wdata_o(dwd),
      .soft_reset_o(srst), .power_down_a_o(pa), .power_down_b_o(pb), .tristate_o(ts),
      .pin_select_a_o(sa), .pin_select_b_o(sb));
   task results;
      begin
         $display("checks %0d errors %0d", checks, num_errors);
         if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task rchk(input [15:0] a, input [7:0] e, input eh);
      begin
         sio_host_model_i.rd(a, d, h);
         `CHK(d, e)
         `CHK(h, eh)
      end
   endtask
   task setreg(input [15:0] a, input [7:0] x, input [7:0] v);
      begin
         sio_host_model_i.wr(a, x);
         sio_host_model_i.wr(a + 16'h0001, v);
      end
   endtask
   initial begin
      #100000;
      num_errors = num_errors + 1;
      results;
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      #2 reset_i = 1'b0;
      repeat (6) @(posedge core_clk_i);
      `CHK({pa, pb, sb, ts, sa, ldn}, 48'hfff002000000)
      $display("test reset done");
      setreg(B, 8'h07, 8'h05);
      `CHK(ldn, 8'h00)
      rchk(B + 16'h0001, 8'h00, 1'b0);
      sio_host_model_i.wr(B, 8'h87);
      sio_host_model_i.wr(16'h0080, 8'h00);
      sio_host_model_i.wr(B, 8'h87);
      `CHK(cm, 1'b0)
      sio_host_model_i.wr(B, 8'h87);
      `CHK(cm, 1'b1)
      $display("test key done");
      setreg(B, 8'h07, 8'h01);
      `CHK(ldn, 8'h01)
      setreg(B, 8'h20, 8'h00);
      rchk(B + 16'h0001, 8'h5a, 1'b1);
      sio_host_model_i.wr(B, 8'h21);
      rchk(B + 16'h0001, 8'h51, 1'b1);
      sio_host_model_i.wr(B, 8'h24);
      rchk(B + 16'h0001, 8'h44, 1'b1);
      sio_host_model_i.wr(B, 8'h27);
      rchk(B + 16'h0001, 8'h00, 1'b1);
      for (i = 0; i < 5; i = i + 1) begin
         ix = (i == 0) ? 8'h22 : (i == 1) ? 8'h23 : (i == 2) ? 8'h25 : (i == 3) ? 8'h29 : 8'h2c;
         setreg(B, ix, ix ^ 8'h5a);
         rchk(B + 16'h0001, ix ^ 8'h5a, 1'b1);
      end
      `CHK({pa, pb, ts, sa, sb}, 40'h78797f7376)
      setreg(B, 8'hf0, 8'h3c);
      `CHK({dwr, dix, dwd}, 17'h1f03c)
      rchk(B + 16'h0001, 8'h55, 1'b1);
      `CHK(drd, 1'b1)
      setreg(B, 8'h02, 8'h01);
      `CHK(srst, 1'b1)
      $display("test access done");
      sio_host_model_i.wr(B, 8'haa);
      `CHK(cm, 1'b0)
      rchk(B + 16'h0001, 8'h00, 1'b0);
      sio_host_model_i.wr(B, 8'h87);
      sio_host_model_i.wr(B, 8'h87);
      `CHK(cm, 1'b1)
      $display("test exit done");
      setreg(B, 8'h26, 8'h40);
      rchk(B + 16'h0001, 8'h00, 1'b0);
      rchk(A + 16'h0001, 8'h40, 1'b1);
      sio_host_model_i.wr(A, 8'haa);
      `CHK(cm, 1'b0)
      $display("test alt port done");
      results;
   end
endmodule
